// ==== rtl/mwd_watchdog.sv ====
// Notes on behaviour
// (R1) The watchdog is a free-running divider chain from the system clock with a selectable tap.
// (R2) The watchdog counts only while the run bit (bit 7) is one.
// (R3) Writing one to bit 6 clears timer, prescaler and the bit itself on the next machine cycle.
// (R4) Bit 5 keeps the watchdog running in idle when set, suspends it when clear, reset zero.
// (R5) The select field 000,010,001,011,100,101,110,111 gives 2,4,8,16,32,64,128,256.
// (R6) Time-out is 12 times prescale times 2^14 oscillator periods.
// (R7) Time-out while enabled requests a system reset.
// (R8) Any reset leaves the watchdog disabled.
// (R9) Any reset clears count and prescaler.
// (R10) Software must restart the watchdog within each time-out period.
// (R11) Software should restart the watchdog after each reset.
// (R12) In idle the watchdog clock is gated by the idle-enable bit.
// (R13) Time-out is a one-cycle reset request and counting then restarts from zero.
// (R14) Bits 4 and 3 read zero and ignore writes.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
module mwd_watchdog (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       idle_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	output logic            reset_req_o,
	output logic            irq_o
);
	typedef struct packed {
		logic [7:0]                      control;
		logic                            restart_pend;
		logic [mwd_pkg::IRQ_WIDTH-1:0]   irq_status;
		logic [mwd_pkg::IRQ_WIDTH-1:0]   irq_mask;
		logic [7:0]                      rdata;
		logic                            reset_req;
		logic                            irq;
	} mwd_state_t;

	mwd_state_t st_reg;
	mwd_state_t st_next;
	logic       machine_tick;
	logic       running;

	mwd_tick_if tk ();

	////////////////////////////////////////////////////////////////////////
	// machine cycle enable, twelve clocks each
	mwd_machine_div u_div (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.enable_i (1'b1),
		.tick_o   (machine_tick)
	);

	mwd_counter u_cnt (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.tk      (tk)
	);

	////////////////////////////////////////////////////////////////////////
	// (R2) run gating
	// (R12) idle gating
	// (R4) idle enable bit
	assign running = st_reg.control[mwd_pkg::RUN_BIT] &&
		(!idle_i || st_reg.control[mwd_pkg::IN_IDLE_BIT]);

	assign tk.tick  = machine_tick;
	assign tk.run   = running;
	// (R13) restart after time-out
	assign tk.clear = (st_reg.restart_pend && machine_tick) || st_reg.reset_req;
	// (R5) select decode
	assign tk.log2_div = mwd_pkg::mwd_sel_to_log2(
		st_reg.control[mwd_pkg::SEL_MSB:mwd_pkg::SEL_LSB]);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_next = st_reg;
		st_next.reset_req = 1'b0;
		st_next.rdata = 8'h00;

		// (R3) self-clearing restart
		if (st_reg.restart_pend && machine_tick) begin
			st_next.restart_pend = 1'b0;
			st_next.control[mwd_pkg::RESTART_BIT] = 1'b0;
		end

		if (wr_i) begin
			case (addr_i)
				mwd_pkg::WATCHDOG_CONTROL_ADDR: begin
					// (R14) reserved bits masked
					st_next.control = wdata_i & mwd_pkg::CONTROL_WRITE_MASK;
					if (wdata_i[mwd_pkg::RESTART_BIT]) begin
						st_next.restart_pend = 1'b1;
					end else if (st_next.restart_pend) begin
						st_next.control[mwd_pkg::RESTART_BIT] = 1'b1;
					end
				end
				mwd_pkg::IRQ_STATUS_ADDR: begin
					st_next.irq_status = st_reg.irq_status &
						~wdata_i[mwd_pkg::IRQ_WIDTH-1:0];
				end
				mwd_pkg::IRQ_MASK_ADDR: begin
					st_next.irq_mask = wdata_i[mwd_pkg::IRQ_WIDTH-1:0];
				end
				default: begin
				end
			endcase
		end

		// (R7) time-out requests reset
		if (tk.timeout && st_reg.control[mwd_pkg::RUN_BIT]) begin
			st_next.reset_req = 1'b1;
			// set wins over a same-cycle clear
			st_next.irq_status[mwd_pkg::IRQ_TIMEOUT_BIT] = 1'b1;
		end

		if (rd_i) begin
			case (addr_i)
				mwd_pkg::WATCHDOG_CONTROL_ADDR: st_next.rdata = st_reg.control;
				mwd_pkg::IRQ_STATUS_ADDR: st_next.rdata = 8'(st_reg.irq_status);
				mwd_pkg::IRQ_MASK_ADDR: st_next.rdata = 8'(st_reg.irq_mask);
				default: st_next.rdata = 8'h00;
			endcase
		end

		st_next.irq = |(st_next.irq_status & st_next.irq_mask);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			// (R8) disabled after reset
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_o     = st_reg.rdata;
	assign reset_req_o = st_reg.reset_req;
	assign irq_o       = st_reg.irq;
endmodule : mwd_watchdog

// ==== rtl/mwd_pkg.sv ====
package mwd_pkg;

	// register map
	localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'h8F;
	localparam logic [7:0] IRQ_STATUS_ADDR       = 8'h90;
	localparam logic [7:0] IRQ_MASK_ADDR         = 8'h91;

	// control field positions
	localparam int RUN_BIT     = 7;
	localparam int RESTART_BIT = 6;
	localparam int IN_IDLE_BIT = 5;
	localparam int SEL_MSB     = 2;
	localparam int SEL_LSB     = 0;
	localparam logic [7:0] CONTROL_WRITE_MASK = 8'hE7;
	localparam logic [7:0] CONTROL_RESET      = 8'h00;

	// interrupt status bits
	localparam int IRQ_TIMEOUT_BIT = 0;
	localparam int IRQ_WIDTH       = 1;
	localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 1'h0;

	// timing: one machine cycle is this many oscillator periods
	localparam int MACHINE_OSC_PERIODS = 12;
	localparam logic [3:0] MACHINE_DIV_LAST = 4'(MACHINE_OSC_PERIODS - 1);
	localparam int TIMER_BITS    = 14;
	localparam int PRESCALE_BITS = 8;

	typedef struct packed {
		logic [7:0] control;
	} mwd_ctl_t;

	// prescale select, bits 1 and 0 swapped while bit 2 is clear, plus one gives the divider exponent
	function automatic logic [3:0] mwd_sel_to_log2(input logic [2:0] sel);
		logic [3:0] r;
		r = 4'h1;
		case (sel)
			3'h0: r = 4'h1;
			3'h2: r = 4'h2;
			3'h1: r = 4'h3;
			3'h3: r = 4'h4;
			3'h4: r = 4'h5;
			3'h5: r = 4'h6;
			3'h6: r = 4'h7;
			3'h7: r = 4'h8;
			default: r = 4'h1;
		endcase
		return r;
	endfunction : mwd_sel_to_log2

endpackage : mwd_pkg

// ==== rtl/mwd_tick_if.sv ====
`timescale 1ns/1ns
interface mwd_tick_if;
	logic       tick;
	logic       clear;
	logic       run;
	logic [3:0] log2_div;
	logic       timeout;

	modport ctrl (
		output tick,
		output clear,
		output run,
		output log2_div,
		input  timeout
	);
	modport cnt (
		input  tick,
		input  clear,
		input  run,
		input  log2_div,
		output timeout
	);
endinterface : mwd_tick_if

// ==== rtl/mwd_counter.sv ====
`timescale 1ns/1ns
module mwd_counter (
	input  wire logic clk_i,
	input  wire logic reset_i,
	mwd_tick_if.cnt   tk
);
	typedef struct packed {
		logic [mwd_pkg::PRESCALE_BITS-1:0] pre;
		logic [mwd_pkg::TIMER_BITS-1:0]    timer;
		logic                              timeout;
	} mwd_cnt_t;

	mwd_cnt_t cnt_reg;
	mwd_cnt_t cnt_next;
	logic     pre_done;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		cnt_next = cnt_reg;
		cnt_next.timeout = 1'b0;
		pre_done = (cnt_reg.pre == 8'((9'h001 << tk.log2_div) - 9'h001));
		if (tk.clear) begin
			// (R3) clear timer and prescaler
			cnt_next.pre   = '0;
			cnt_next.timer = '0;
		end else if (tk.run && tk.tick) begin
			// (R1) prescaler feeds timer
			if (pre_done) begin
				cnt_next.pre = '0;
				// (R6) 14-bit count of prescaled cycles
				cnt_next.timer = cnt_reg.timer + 14'h0001;
				if (cnt_reg.timer == 14'h3FFF) begin
					cnt_next.timeout = 1'b1;
				end
			end else begin
				cnt_next.pre = cnt_reg.pre + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		// (R9) reset clears count
		if (reset_i) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign tk.timeout = cnt_reg.timeout;
endmodule : mwd_counter

// ==== rtl/mwd_machine_div.sv ====
`timescale 1ns/1ns
module mwd_machine_div (
	input  wire logic clk_i,
	input  wire logic reset_i,
	input  wire logic enable_i,
	output logic      tick_o
);
	typedef struct packed {
		logic [3:0] cnt;
		logic       tick;
	} mwd_div_t;

	mwd_div_t div_reg;
	mwd_div_t div_next;

	always_comb begin
		div_next = div_reg;
		div_next.tick = 1'b0;
		if (enable_i) begin
			if (div_reg.cnt == mwd_pkg::MACHINE_DIV_LAST) begin
				div_next.cnt  = 4'h0;
				div_next.tick = 1'b1;
			end else begin
				div_next.cnt = div_reg.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end

	assign tick_o = div_reg.tick;
endmodule : mwd_machine_div

// ==== verification/mwd_assertions.sv ====
`timescale 1ns/1ns
module mwd_checker (
	input wire logic       clk_i,
	input wire logic       reset_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       reset_req_o,
	input wire logic       irq_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	////////////////////////////////////////////////////////////////
	sequence s_ctl_wr;
		wr_i && addr_i == mwd_pkg::WATCHDOG_CONTROL_ADDR;
	endsequence
	sequence s_restart;
		s_ctl_wr ##0 wdata_i[6];
	endsequence
	sequence s_stop;
		s_ctl_wr ##0 !wdata_i[7];
	endsequence
	////////////////////////////////////////////////////////////////
	property p_rd_quiet;
		!$past(rd_i) |-> rdata_o == 8'h00;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read");
	property p_rsvd_zero;
		$past(rd_i) && $past(addr_i) == mwd_pkg::WATCHDOG_CONTROL_ADDR |-> rdata_o[4:3] == 2'h0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");
	property p_req_pulse;
		$rose(reset_req_o) |=> $fell(reset_req_o);
	endproperty
	a_req_pulse: assert property (p_req_pulse) else $error("request not one cycle");
	property p_req_gap;
		reset_req_o |=> !reset_req_o [*8];
	endproperty
	a_req_gap: assert property (p_req_gap) else $error("requests too close");
	property p_reset_quiet;
		$fell(reset_i) |-> !reset_req_o && !irq_o && rdata_o == 8'h00;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs after reset");
	property p_no_early;
		$fell(reset_i) |-> !reset_req_o [*8];
	endproperty
	a_no_early: assert property (p_no_early) else $error("request after reset");
	property p_restart;
		s_restart |-> ##13 !reset_req_o [*8];
	endproperty
	a_restart: assert property (p_restart) else $error("request after restart");
	property p_stop;
		s_stop |-> ##4 !reset_req_o [*8];
	endproperty
	a_stop: assert property (p_stop) else $error("request while stopped");
endmodule : mwd_checker

bind mwd_watchdog mwd_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.reset_req_o(reset_req_o), .irq_o(irq_o));

// ==== verification/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
	localparam logic [7:0] CA = mwd_pkg::WATCHDOG_CONTROL_ADDR;
	localparam logic [7:0] SA = mwd_pkg::IRQ_STATUS_ADDR;
	localparam logic [7:0] MA = mwd_pkg::IRQ_MASK_ADDR;
	logic       clk_i   = 1'b0;
	logic       reset_i = 1'b1;
	logic       idle_i  = 1'b0;
	logic [7:0] addr_i  = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i    = 1'b0;
	logic       rd_i    = 1'b0;
	logic [7:0] rdata_o;
	logic       reset_req_o;
	logic       irq_o;
	int         fail_count = 0;
	int         n_tests    = 0;
	always #4 clk_i = ~clk_i;
	mwd_watchdog uut (.clk_i(clk_i), .reset_i(reset_i), .idle_i(idle_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.reset_req_o(reset_req_o), .irq_o(irq_o));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value %0s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk("rdata_o", exp, rdata_o);
	endtask : rd
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(CA, 8'h00);
		rd(SA, 8'h00);
		rd(MA, 8'h00);
		wr(CA, 8'h40);
		repeat (13) @(posedge clk_i);
		$display("test reset done");
		wr(CA, 8'hBF);
		rd(CA, 8'hA7);
		for (int s = 0; s < 8; s++) begin
			wr(CA, 8'hA0 | 8'(s));
			rd(CA, 8'hA0 | 8'(s));
		end
		$display("test control done");
		@(posedge clk_i);
		idle_i <= 1'b1;
		wr(CA, 8'hC1);
		repeat (13) @(posedge clk_i);
		rd(CA, 8'h81);
		// suspended in idle: the cleared timer must not move
		repeat (100) @(posedge clk_i);
		chk("timer_held", 8'h00, uut.u_cnt.cnt_reg.timer[7:0]);
		wr(CA, 8'hA0);
		repeat (60) @(posedge clk_i);
		chk("timer_runs", 8'h01, {7'h00, uut.u_cnt.cnt_reg.timer != 14'h0000});
		chk("reset_req_o", 8'h00, {7'h00, reset_req_o});
		idle_i <= 1'b0;
		$display("test restart done");
		wr(8'h92, 8'hFF);
		rd(8'h92, 8'h00);
		wr(MA, 8'h01);
		rd(MA, 8'h01);
		chk("irq_o", 8'h00, {7'h00, irq_o});
		wr(SA, 8'h01);
		rd(SA, 8'h00);
		$display("test interrupt done");
		wr(CA, 8'h00);
		rd(CA, 8'h00);
		wr(CA, 8'hA3);
		@(posedge clk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(CA, 8'h00);
		rd(MA, 8'h00);
		chk("reset_req_o", 8'h00, {7'h00, reset_req_o});
		$display("test second reset done");
		stop_test();
	end
endmodule : tb_top
